//--- hw/bcs_ctrl.sv
// boost converter gate timing, soft-start sequencer and apb registers
`timescale 1ns/1ps
`include "bcs_consts.svh"

// Contract
// - gate on at switching clock rising edge
// - ignore turn-off during minimum on-time
// - peak trip after blanking ends the pulse
// - 7-bit reference dac code, 128 steps
// - feedback overvoltage raises fault, stops switching
// - feedback above skip level suppresses pulses
// - open fault only at open-detect level
// - low comp asserts pulse skip, halts
// - comp clamp ramps up, capped at ceiling
// - 200 mV limits, 240 mV faults, opens switch
// - bus variant starts on enable bit set
// - standalone variant sets enable at reset
// - start at 25% frequency, 20% limit
// - frequency and limit rise in steps
// - skip level ends soft-start, enables channels
// - dac steps down once dimming valid
// - optimize only with active long-on channels
// - overvoltage latches flag, drives fault pin
// - overcurrent latches flag, enters auto-recovery
// - enable cleared in recovery goes standby
module bcs_ctrl #(
    parameter int      SS_STEPS   = 4,     // soft-start steps
    parameter int      SS_DWELL   = 5000,  // cycles per step
    parameter int      DAC_DWELL  = 256,   // cycles per dac down step
    parameter bit      STANDALONE = 1'b0,  // enable bit set at reset
    parameter int      NCH        = 4      // channel count
) (
    input  wire logic              pclk,          // main clock
    input  wire logic              presetn,       // async reset, low
    input  wire logic              psel,          // apb select
    input  wire logic              penable,       // apb enable
    input  wire logic              pwrite,        // apb direction
    input  wire logic [11:0]       paddr,         // apb address
    input  wire logic [31:0]       pwdata,        // apb write data
    output logic      [31:0]       prdata,        // apb read data
    output logic                   pready,        // apb ready
    output logic                   pslverr,       // apb error
    input  wire logic              switching_clock, // switching clock pin
    input  wire bcs_pkg::bcs_cmp_t cmp_in,        // comparator outputs
    input  wire logic              dim_valid,     // valid dimming applied
    input  wire logic [NCH-1:0]    ch_on,         // channel currently on
    output logic                   gate_drive,    // low-side gate
    output logic                   pulse_skip,    // skip signal
    output logic                   line_switch_on, // input pmos on
    output logic                   fault_n,       // fault pin, low
    output logic [`BCS_DAC_BITS-1:0] dac_code,    // reference dac code
    output logic [7:0]             freq_pct,      // switching freq percent
    output logic [7:0]             ilim_pct,      // current limit percent
    output logic [7:0]             clamp_pct,     // comp clamp of ceiling
    output logic [NCH-1:0]         ch_enable      // channel enables
);
    import bcs_pkg::*;

    localparam int TON_CYC = `BCS_TON_MIN_CYC;
    localparam int SSW = $clog2(SS_DWELL + 1);
    localparam int DW  = $clog2(DAC_DWELL + 1);

    // three-stage sync of pins; second and third must agree
    logic [2:0] sw_sync_reg;
    logic [6:0] c1_reg, c2_reg, c3_reg;
    logic       sw_reg;
    bcs_cmp_t   cmp_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_sync_reg <= 3'h0;
            c1_reg <= 7'h00;
            c2_reg <= 7'h00;
            c3_reg <= 7'h00;
        end else begin
            sw_sync_reg <= {sw_sync_reg[1:0], switching_clock};
            c1_reg <= cmp_in;
            c2_reg <= c1_reg;
            c3_reg <= c2_reg;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_reg  <= 1'b0;
            cmp_reg <= '0;
        end else begin
            if (sw_sync_reg[1] == sw_sync_reg[2])
                sw_reg <= sw_sync_reg[2];
            for (int i = 0; i < 7; i++)
                if (c2_reg[i] == c3_reg[i])
                    cmp_reg[i] <= c3_reg[i];
        end
    end
    logic sw_prev_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            sw_prev_reg <= 1'b0;
        else
            sw_prev_reg <= sw_reg;
    end
    wire sw_rise = sw_reg & ~sw_prev_reg;

    // registers
    logic [31:0] ctrl_reg;
    logic [1:0]  fmask_reg;
    logic        ovp_flag_reg, ocp_flag_reg;
    wire         wr_en = psel & penable & pwrite;
    wire         rd_sel_ok = (paddr == `BCS_ADDR_CTRL) || (paddr == `BCS_ADDR_STATUS) ||
                             (paddr == `BCS_ADDR_DAC) || (paddr == `BCS_ADDR_FAULTMASK);
    wire         st_wr = wr_en && paddr == `BCS_ADDR_STATUS;
    wire         dev_en = ctrl_reg[`BCS_CTRL_EN_BIT];
    wire [NCH-1:0] ch_cfg = ctrl_reg[`BCS_CTRL_CH_LSB +: NCH];
    bcs_state_t  state_reg, state_next;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~rd_sel_ok;

    // ctrl register; standalone variant comes up enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctrl_reg <= STANDALONE ? 32'h0000_0001 : `BCS_CTRL_RST;
        else if (wr_en && paddr == `BCS_ADDR_CTRL)
            ctrl_reg <= pwdata;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            fmask_reg <= 2'h0;
        else if (wr_en && paddr == `BCS_ADDR_FAULTMASK)
            fmask_reg <= pwdata[1:0];
    end

    // sticky fault flags, write one to clear; a new event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovp_flag_reg <= 1'b0;
            ocp_flag_reg <= 1'b0;
        end else begin
            ovp_flag_reg <= cmp_reg.ovp | (ovp_flag_reg & ~(st_wr & pwdata[0]));
            ocp_flag_reg <= cmp_reg.input_overcurrent_flag | (ocp_flag_reg & ~(st_wr & pwdata[1]));
        end
    end
    assign fault_n = ~((ovp_flag_reg & ~fmask_reg[0]) | (ocp_flag_reg & ~fmask_reg[1]));

    // read mux
    always_comb begin
        prdata = 32'h0000_0000;
        case (paddr)
            `BCS_ADDR_CTRL:      prdata = ctrl_reg;
            `BCS_ADDR_STATUS:    prdata = {25'h0, cmp_reg.open_lvl & (state_reg == BCS_RUN),
                                           1'b0, state_reg, ocp_flag_reg, ovp_flag_reg};
            `BCS_ADDR_DAC:       prdata = {25'h0, dac_code};
            `BCS_ADDR_FAULTMASK: prdata = {30'h0, fmask_reg};
            default:             prdata = 32'h0000_0000;
        endcase
    end

    // soft-start step counter
    logic [7:0]     step_reg;
    logic [SSW-1:0] dwell_reg;
    wire crit = cmp_reg.ovp | cmp_reg.input_overcurrent_flag;
    wire dwell_done = (dwell_reg == SSW'(SS_DWELL - 1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_reg  <= 8'h00;
            dwell_reg <= '0;
        end else if (state_reg != BCS_SOFTSTART || crit) begin
            step_reg  <= 8'h00;
            dwell_reg <= '0;
        end else if (dwell_done) begin
            dwell_reg <= '0;
            if (step_reg < 8'(SS_STEPS))
                step_reg <= step_reg + 8'h01;
        end else begin
            dwell_reg <= dwell_reg + SSW'(1);
        end
    end

    // sequencer state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            BCS_STANDBY:   if (dev_en) state_next = BCS_SOFTSTART;
            BCS_SOFTSTART: begin
                if (!dev_en)          state_next = BCS_STANDBY;
                else if (crit)        state_next = BCS_RECOVER;
                else if (cmp_reg.skip) state_next = BCS_RUN;
            end
            BCS_RUN: begin
                if (!dev_en)   state_next = BCS_STANDBY;
                else if (crit) state_next = BCS_RECOVER;
            end
            BCS_RECOVER: begin
                if (!dev_en)   state_next = BCS_STANDBY;
                else if (!crit) state_next = BCS_SOFTSTART;
            end
            default: state_next = BCS_STANDBY;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            state_reg <= BCS_STANDBY;
        else
            state_reg <= state_next;
    end

    // frequency, limit and clamp percentages follow the step
    function automatic logic [7:0] ramp_pct(input logic [7:0] base, input logic [7:0] st);
        logic [15:0] v;
        v = 16'(base) + 16'((16'(8'd100 - base) * 16'(st)) / 16'(SS_STEPS));
        return (v > 16'd100) ? 8'd100 : v[7:0];
    endfunction
    wire ss = (state_reg == BCS_SOFTSTART);
    assign freq_pct  = ss ? ramp_pct(8'(`BCS_START_FREQ_PCT), step_reg) : 8'd100;
    assign ilim_pct  = ss ? ramp_pct(8'(`BCS_START_ILIM_PCT), step_reg) : 8'd100;
    assign clamp_pct = ss ? ramp_pct(8'h00, step_reg) : 8'd100;
    assign line_switch_on = (state_reg == BCS_SOFTSTART) || (state_reg == BCS_RUN);
    assign ch_enable = (state_reg == BCS_RUN) ? ch_cfg : '0;

    // switching allowed; skip, comp low and overvoltage all block pulses
    wire sw_allow = line_switch_on & ~cmp_reg.ovp & ~cmp_reg.skip & ~cmp_reg.comp_low;
    assign pulse_skip = cmp_reg.comp_low;

    // gate pulse: on at rise, blanking, off on peak or cycle limit
    logic [7:0] blank_reg;
    logic       gate_reg;
    wire        off_req = cmp_reg.peak | cmp_reg.ilim;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_reg  <= 1'b0;
            blank_reg <= 8'h00;
        end else if (!sw_allow) begin
            gate_reg  <= 1'b0;
            blank_reg <= 8'h00;
        end else if (sw_rise) begin
            gate_reg  <= 1'b1;
            blank_reg <= 8'(TON_CYC);
        end else if (blank_reg != 8'h00) begin
            blank_reg <= blank_reg - 8'h01;
        end else if (off_req) begin
            gate_reg <= 1'b0;
        end
    end
    assign gate_drive = gate_reg;

    // on-time of each channel, saturated one above the minimum
    logic [NCH-1:0] long_on_reg;
    logic [5:0]     on_cnt_reg [NCH];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            long_on_reg <= '0;
            for (int i = 0; i < NCH; i++)
                on_cnt_reg[i] <= 6'h00;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (!ch_on[i]) begin
                    on_cnt_reg[i]  <= 6'h00;
                end else if (on_cnt_reg[i] <= 6'(`BCS_OPT_MIN_ON)) begin
                    on_cnt_reg[i] <= on_cnt_reg[i] + 6'h01;
                end
                long_on_reg[i] <= on_cnt_reg[i] > 6'(`BCS_OPT_MIN_ON);
            end
        end
    end
    wire [NCH-1:0] act = ch_on & ch_enable;
    wire opt_ok = (act != '0) && ((act & ~long_on_reg) == '0);

    // dac starts at top and rolls down while optimizing
    logic [DW-1:0] dac_dw_reg;
    logic [`BCS_DAC_BITS-1:0] dac_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_reg    <= `BCS_DAC_MAX_CODE;
            dac_dw_reg <= '0;
        end else if (state_reg != BCS_RUN) begin
            dac_reg    <= `BCS_DAC_MAX_CODE;
            dac_dw_reg <= '0;
        end else if (dim_valid && opt_ok) begin
            if (dac_dw_reg == DW'(DAC_DWELL - 1)) begin
                dac_dw_reg <= '0;
                if (dac_reg != '0)
                    dac_reg <= dac_reg - 7'h01;
            end else begin
                dac_dw_reg <= dac_dw_reg + DW'(1);
            end
        end
    end
    assign dac_code = dac_reg;

    // checks
    property p_blank;
        @(posedge pclk) disable iff (!presetn)
        $rose(gate_reg) && sw_allow |=> gate_reg || !sw_allow;
    endproperty
    a_blank: assert property (p_blank) else $error("gate dropped in blanking");
    property p_on;
        @(posedge pclk) disable iff (!presetn)
        sw_rise && sw_allow |=> gate_reg;
    endproperty
    a_on: assert property (p_on) else $error("gate not on at edge");
    property p_off;
        @(posedge pclk) disable iff (!presetn)
        gate_reg && blank_reg == 8'h00 && off_req && !sw_rise |=> !gate_reg;
    endproperty
    a_off: assert property (p_off) else $error("gate not off at peak");
    property p_ovp;
        @(posedge pclk) disable iff (!presetn)
        cmp_reg.ovp |=> !gate_reg && ovp_flag_reg;
    endproperty
    a_ovp: assert property (p_ovp) else $error("overvoltage not handled");
    property p_skip;
        @(posedge pclk) disable iff (!presetn)
        pulse_skip |=> !gate_reg;
    endproperty
    a_skip: assert property (p_skip) else $error("switching during skip");
    property p_rec;
        @(posedge pclk) disable iff (!presetn)
        state_reg == BCS_RECOVER && !dev_en |=> state_reg == BCS_STANDBY;
    endproperty
    a_rec: assert property (p_rec) else $error("recovery not left");
    property p_start;
        @(posedge pclk) disable iff (!presetn)
        $rose(ss) |-> freq_pct == 8'(`BCS_START_FREQ_PCT) && ilim_pct == 8'(`BCS_START_ILIM_PCT);
    endproperty
    a_start: assert property (p_start) else $error("bad start levels");
    property p_ocp;
        @(posedge pclk) disable iff (!presetn)
        cmp_reg.input_overcurrent_flag && state_reg == BCS_RUN |=> state_reg == BCS_RECOVER && !line_switch_on;
    endproperty
    a_ocp: assert property (p_ocp) else $error("overcurrent not recovered");
    property p_dac;
        @(posedge pclk) disable iff (!presetn)
        !opt_ok |=> $stable(dac_reg) || state_reg != BCS_RUN;
    endproperty
    a_dac: assert property (p_dac) else $error("dac moved without optimizing");
    c_run: cover property (@(posedge pclk) disable iff (!presetn) state_reg == BCS_RUN);
    c_rec: cover property (@(posedge pclk) disable iff (!presetn) state_reg == BCS_RECOVER);
    c_dac: cover property (@(posedge pclk) disable iff (!presetn) $fell(dac_reg[0]));
endmodule

//--- hw/bcs_consts.svh
// constants for the boost converter soft-start sequencer
`ifndef BCS_CONSTS_SVH
`define BCS_CONSTS_SVH
`define BCS_ADDR_CTRL      12'h000
`define BCS_ADDR_STATUS    12'h004
`define BCS_ADDR_DAC       12'h008
`define BCS_ADDR_FAULTMASK 12'h00C
`define BCS_DAC_BITS       7
`define BCS_DAC_STEPS      128
`define BCS_DAC_STEP_UV    2244
`define BCS_DAC_MIN_MV     795
`define BCS_DAC_MAX_MV     1080
`define BCS_DAC_MAX_CODE   7'h7F
`define BCS_OVP_MV         1180
`define BCS_SKIP_MV        1090
`define BCS_OPEN_MV        1030
`define BCS_COMP_SKIP_MV   725
`define BCS_CLAMP_MAX_MV   1900
`define BCS_ILIM_MV        200
`define BCS_INPUT_OVERCURRENT_FLAG_MV        240
`define BCS_START_FREQ_PCT 25
`define BCS_START_ILIM_PCT 20
`define BCS_OPT_MIN_ON     48
`define BCS_TON_MIN_NS     100
`define BCS_CLK_NS         20
`define BCS_TON_MIN_CYC    ((`BCS_TON_MIN_NS + `BCS_CLK_NS - 1) / `BCS_CLK_NS)
`define BCS_CTRL_RST       32'h0000_0000
`define BCS_CTRL_EN_BIT    0
`define BCS_CTRL_CH_LSB    4
`endif

//--- hw/bcs_pkg.sv
// types for the boost converter soft-start sequencer
package bcs_pkg;
    typedef enum logic [2:0] {
        BCS_STANDBY, BCS_SOFTSTART, BCS_RUN, BCS_RECOVER
    } bcs_state_t;
    typedef struct packed {
        logic ovp;      // feedback at overvoltage level
        logic skip;     // feedback above skip level
        logic open_lvl; // feedback at open-detect level
        logic comp_low; // comp would fall below skip level
        logic ilim;     // sense at cycle limit level
        logic input_overcurrent_flag;     // sense at overcurrent level
        logic peak;     // peak current comparator tripped
    } bcs_cmp_t;
endpackage

//--- verif/bcs_far_side.sv
// behavioural power stage and comparator front end facing the sequencer
`timescale 1ns/1ps
module bcs_far_side #(
    parameter int SW_HALF = 20  // main clock cycles per switching clock half period
) (
    input  wire logic              pclk,            // main clock
    input  wire logic              presetn,         // async reset, low
    input  wire logic              gate_drive,      // low-side gate from the block
    input  wire bcs_pkg::bcs_cmp_t lvl,             // static comparator levels from the bench
    input  wire logic [7:0]        peak_dly,        // cycles of on-time before peak trips
    output logic                   switching_clock, // free-running switching clock
    output bcs_pkg::bcs_cmp_t      cmp_in           // comparator outputs to the block
);
    import bcs_pkg::*;
    logic [7:0] sw_cnt_reg;
    logic [7:0] on_cnt_reg;
    // switching clock runs free, derived from the main clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_cnt_reg      <= 8'h00;
            switching_clock <= 1'b0;
        end else if (sw_cnt_reg == 8'(SW_HALF - 1)) begin
            sw_cnt_reg      <= 8'h00;
            switching_clock <= ~switching_clock;
        end else begin
            sw_cnt_reg <= sw_cnt_reg + 8'h01;
        end
    end
    // inductor current ramps while the gate is on; saturating so a stuck gate cannot wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_cnt_reg <= 8'h00;
        end else if (!gate_drive) begin
            on_cnt_reg <= 8'h00;
        end else if (on_cnt_reg != 8'hFF) begin
            on_cnt_reg <= on_cnt_reg + 8'h01;
        end
    end
    // ramp peak trip only while the gate is on, so the block sees it fall with the gate; lvl.peak passes through at any time
    always_comb begin
        cmp_in      = lvl;
        cmp_in.peak = lvl.peak | (gate_drive && on_cnt_reg >= peak_dly);
    end
endmodule

//--- verif/bcs_ctrl_test.sv
// self-checking bench for the boost converter soft-start sequencer
`timescale 1ns/1ps
`include "bcs_consts.svh"
module bcs_ctrl_test;
    import bcs_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, switching_clock;
    logic        dim_valid, gate_drive, pulse_skip, line_switch_on, fault_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  ch_on, ch_enable;
    logic [6:0]  dac_code;
    logic [7:0]  freq_pct, ilim_pct, clamp_pct, peak_dly;
    bcs_cmp_t    cmp_in, lvl;
    int          miscompares, checks_done, cyc;

    bcs_ctrl #(.SS_STEPS(4), .SS_DWELL(8), .DAC_DWELL(4), .STANDALONE(1'b0)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .switching_clock(switching_clock), .cmp_in(cmp_in), .dim_valid(dim_valid),
        .ch_on(ch_on), .gate_drive(gate_drive), .pulse_skip(pulse_skip),
        .line_switch_on(line_switch_on), .fault_n(fault_n), .dac_code(dac_code),
        .freq_pct(freq_pct), .ilim_pct(ilim_pct), .clamp_pct(clamp_pct), .ch_enable(ch_enable));
    bcs_far_side far_u (
        .pclk(pclk), .presetn(presetn), .gate_drive(gate_drive), .lvl(lvl),
        .peak_dly(peak_dly), .switching_clock(switching_clock), .cmp_in(cmp_in));

    task test_done;
        if (miscompares == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one apb transfer; request held until pready is seen at a rising edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        // pready ends this wait; with no limit of its own, only the bench timeout ends it if pready never comes
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // rising gate edges over n cycles, after letting the synchroniser settle
    task gates(input int n, output int g);
        logic p;
        repeat (6) @(posedge pclk);
        g = 0;
        p = gate_drive;
        repeat (n) begin @(posedge pclk); if (gate_drive === 1'b1 && p !== 1'b1) g++; p = gate_drive; end
    endtask
    // latency from a switching clock rise to gate on, and the pulse length
    task pulse(output int lat, output int len);
        int n;
        lat = 0; len = 0; n = 0;
        while (switching_clock !== 1'b0 && n < 100) begin @(posedge pclk); n++; end
        while (switching_clock !== 1'b1 && n < 100) begin @(posedge pclk); n++; end
        while (gate_drive !== 1'b1 && lat < 20) begin @(posedge pclk); lat++; end
        while (gate_drive === 1'b1 && len < 100) begin @(posedge pclk); len++; end
    endtask

    task t_reset;
        logic [31:0] q; logic e;
        chk("dac_reset", 7'h7F, dac_code);
        chk("fault_n_reset", 1'b1, fault_n);
        chk("gate_reset", 1'b0, gate_drive);
        apb(1'b0, 12'h010, 32'h0, q, e);
        chk("unmapped_err", 1'b1, e);
        chk("unmapped_data", 32'h0, q);
        apb(1'b0, `BCS_ADDR_STATUS, 32'h0, q, e);
        chk("state_standby", BCS_STANDBY, q[4:2]);
    endtask
    task t_soft;
        logic [31:0] q; logic e; logic [7:0] c0; int n, g;
        apb(1'b1, `BCS_ADDR_CTRL, 32'h0000_0031, q, e);
        repeat (2) @(posedge pclk);
        c0 = clamp_pct;
        chk("freq_start", 8'd25, freq_pct);
        chk("ilim_start", 8'd20, ilim_pct);
        chk("line_sw_on", 1'b1, line_switch_on);
        repeat (40) @(posedge pclk);
        chk("freq_step", 1'b1, freq_pct > 8'd25);
        chk("ilim_step", 1'b1, ilim_pct > 8'd20);
        chk("clamp_ramp", 1'b1, clamp_pct > c0 && clamp_pct <= 8'd100);
        lvl.ovp <= 1'b1;
        gates(60, g);
        chk("ovp_gates", 32'd0, g);
        chk("ovp_fault_n", 1'b0, fault_n);
        lvl.ovp <= 1'b0;
        n = 0;
        while (freq_pct !== 8'd25 && n < 60) begin @(posedge pclk); n++; end
        chk("restart_freq", 8'd25, freq_pct);
        apb(1'b0, `BCS_ADDR_STATUS, 32'h0, q, e);
        chk("ovp_flag", 1'b1, q[0]);
        apb(1'b1, `BCS_ADDR_STATUS, 32'h1, q, e);
        apb(1'b0, `BCS_ADDR_STATUS, 32'h0, q, e);
        chk("ovp_flag_clr", 1'b0, q[0]);
    endtask
    task t_run;
        logic [31:0] q; logic e; int n, g;
        lvl.skip <= 1'b1;
        n = 0;
        while (freq_pct !== 8'd100 && n < 200) begin @(posedge pclk); n++; end
        chk("run_freq", 8'd100, freq_pct);
        chk("run_ilim", 8'd100, ilim_pct);
        chk("run_ch_en", 4'b0011, ch_enable);
        apb(1'b0, `BCS_ADDR_STATUS, 32'h0, q, e);
        chk("state_run", BCS_RUN, q[4:2]);
        chk("open_idle", 1'b0, q[6]);
        lvl.open_lvl <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b0, `BCS_ADDR_STATUS, 32'h0, q, e);
        chk("open_fault", 1'b1, q[6]);
        lvl.open_lvl <= 1'b0;
        gates(80, g);
        chk("skip_gates", 32'd0, g);
        lvl.skip <= 1'b0;
    endtask
    task t_gate;
        int lat, len;
        peak_dly <= 8'd0;
        pulse(lat, len);
        chk("gate_latency", 1'b1, lat >= 1 && lat <= 7);
        chk("blank_min", 1'b1, len >= 5);
        chk("blank_trip", 1'b1, len <= 8);
        peak_dly <= 8'd20;
        pulse(lat, len);
        chk("slow_trip", 1'b1, len >= 20 && len <= 28);
        peak_dly <= 8'd60;
        lvl.ilim <= 1'b1;
        pulse(lat, len);
        chk("ilim_trip", 1'b1, len >= 5 && len <= 8);
        lvl.ilim <= 1'b0;
    endtask
    task t_comp;
        int g;
        lvl.comp_low <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("pulse_skip_on", 1'b1, pulse_skip);
        gates(80, g);
        chk("comp_gates", 32'd0, g);
        lvl.comp_low <= 1'b0;
        repeat (8) @(posedge pclk);
        chk("pulse_skip_off", 1'b0, pulse_skip);
    endtask
    task t_opt;
        ch_on <= 4'b0011;
        repeat (150) @(posedge pclk);
        chk("dac_no_dim", 7'h7F, dac_code);
        dim_valid <= 1'b1;
        ch_on <= 4'b0000;
        repeat (150) @(posedge pclk);
        chk("dac_no_ch", 7'h7F, dac_code);
        ch_on <= 4'b0011;
        repeat (200) @(posedge pclk);
        chk("dac_down", 1'b1, dac_code < 7'h7F);
    endtask
    task t_ovp;
        logic [31:0] q; logic e; int g;
        apb(1'b1, `BCS_ADDR_FAULTMASK, 32'h1, q, e);
        lvl.ovp <= 1'b1;
        gates(60, g);
        chk("ovp_gates_run", 32'd0, g);
        chk("ovp_masked", 1'b1, fault_n);
        apb(1'b0, `BCS_ADDR_STATUS, 32'h0, q, e);
        chk("ovp_flag_run", 1'b1, q[0]);
        apb(1'b1, `BCS_ADDR_FAULTMASK, 32'h0, q, e);
        repeat (3) @(posedge pclk);
        chk("ovp_unmasked", 1'b0, fault_n);
        lvl.ovp <= 1'b0;
        // let the comparator level leave the synchroniser, else the set wins over the clear
        repeat (6) @(posedge pclk);
        apb(1'b1, `BCS_ADDR_STATUS, 32'h1, q, e);
        repeat (3) @(posedge pclk);
        chk("ovp_cleared", 1'b1, fault_n);
    endtask
    task t_ocp;
        logic [31:0] q; logic e;
        lvl.input_overcurrent_flag <= 1'b1;
        repeat (10) @(posedge pclk);
        chk("ocp_line_sw", 1'b0, line_switch_on);
        chk("ocp_fault_n", 1'b0, fault_n);
        apb(1'b0, `BCS_ADDR_STATUS, 32'h0, q, e);
        chk("ocp_flag", 1'b1, q[1]);
        chk("state_recover", BCS_RECOVER, q[4:2]);
        apb(1'b1, `BCS_ADDR_CTRL, 32'h0, q, e);
        apb(1'b0, `BCS_ADDR_STATUS, 32'h0, q, e);
        chk("state_standby_off", BCS_STANDBY, q[4:2]);
        lvl.input_overcurrent_flag <= 1'b0;
    endtask

    // clock and hang guard
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            test_done();
        end
    end
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0; lvl = '0; peak_dly = 8'h00; dim_valid = 1'b0; ch_on = 4'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_soft();
        t_run();
        t_gate();
        t_comp();
        t_opt();
        t_ovp();
        t_ocp();
        test_done();
    end
endmodule
